// ---- vt_conv_regs.vh ----
`ifndef VT_CONV_REGS_VH
`define VT_CONV_REGS_VH
`define CTRL_OFFSET 32'h40030010
`define STATUS_OFFSET 32'h40030014
`define IRQ_MASK_OFFSET 32'h4003001C
`define CTRL_RESET 32'h00000000
`define CTRL_IMPL_MASK 32'h000B33D0
`define STATUS_RESET 3'h0
`define MASK_RESET 3'h0
`define EN_BIT 19
`define BYP_HI 17
`define BYP_LO 16
`define DIAG_HI 13
`define DIAG_LO 12
`define CODE_BIT 9
`define CH_HI 8
`define CH_LO 6
`define REF_BIT 4
`define SETTLE_CYCLES_DEF 16'h0400
`define ST_VOLT_RDY 0
`define ST_TEMP_RDY 1
`define ST_RESTART 2
`endif

// ---- voltage_temp_adc_control.v ----
// The implementer's own choice: strobed register access.
`timescale 1ns/10ps
`include "vt_conv_regs.vh"
// What this block does
// - any control write resets secondary converter
// - restart aligned to primary converter frame
// - withhold results until filter settling passes
// - enable low powers down, clears ready
// - bypass field selects input buffers
// - diagnostic field drives 50 uA sources
// - coding bit selects bipolar or unipolar
// - channel field routes converter input
// - reference bit selects internal or supply
module voltage_temp_adc_control #(
  parameter SETTLE_CYCLES = `SETTLE_CYCLES_DEF
) (
  input wire sys_clk_i,
  input wire sys_rst_i,
  input wire [31:0] addr_i,
  input wire [31:0] wdata_i,
  input wire wr_i,
  input wire rd_i,
  output reg [31:0] rdata_o,
  input wire primary_frame_i,
  input wire conv_volt_done_i,
  input wire conv_temp_done_i,
  input wire [23:0] conv_data_i,
  output reg converter_power_enable_o,
  output reg converter_reset_o,
  output reg [1:0] input_buffer_bypass_o,
  output reg [1:0] diagnostic_current_select_o,
  output reg output_coding_select_o,
  output reg [2:0] input_channel_select_o,
  output reg reference_select_o,
  output reg voltage_result_ready_o,
  output reg temperature_result_ready_o,
  output reg [23:0] result_o,
  output reg irq_o
);
  localparam ST_OFF = 2'h0;
  localparam ST_WAIT = 2'h1;
  localparam ST_SETTLE = 2'h2;
  localparam ST_RUN = 2'h3;
  reg [31:0] ctrl_reg;
  reg [1:0] state_reg;
  reg [15:0] settle_reg;
  reg [2:0] status_reg;
  reg [2:0] mask_reg;
  wire ctrl_wr = wr_i && (addr_i == `CTRL_OFFSET);
  wire stat_wr = wr_i && (addr_i == `STATUS_OFFSET);
  wire mask_wr = wr_i && (addr_i == `IRQ_MASK_OFFSET);
  wire enabled = ctrl_reg[`EN_BIT];
  wire running = (state_reg == ST_RUN) && enabled;
  wire [31:0] ctrl_masked = wdata_i & `CTRL_IMPL_MASK;
  wire restart_evt = (state_reg == ST_WAIT) && primary_frame_i && !ctrl_wr;
  // unipolar coding clamps negative results to zero
  wire [23:0] coded = (ctrl_reg[`CODE_BIT] && conv_data_i[23]) ? 24'h000000 : conv_data_i;
  wire [2:0] events = {restart_evt, running && conv_temp_done_i, running && conv_volt_done_i};

  always @(posedge sys_clk_i) begin
    if (sys_rst_i) begin
      ctrl_reg <= `CTRL_RESET;
    end else if (ctrl_wr) begin
      ctrl_reg <= ctrl_masked;
    end
  end

  always @(posedge sys_clk_i) begin
    if (sys_rst_i) begin
      state_reg <= ST_OFF;
      settle_reg <= 16'h0000;
    end else if (ctrl_wr) begin
      state_reg <= ctrl_masked[`EN_BIT] ? ST_WAIT : ST_OFF;
      settle_reg <= 16'h0000;
    end else begin
      case (state_reg)
        ST_OFF: begin
          state_reg <= ST_OFF;
        end
        ST_WAIT: begin
          if (primary_frame_i) begin
            state_reg <= ST_SETTLE;
          end
        end
        ST_SETTLE: begin
          if (settle_reg >= SETTLE_CYCLES - 1) begin
            state_reg <= ST_RUN;
          end else begin
            settle_reg <= settle_reg + 16'h0001;
          end
        end
        ST_RUN: begin
          state_reg <= ST_RUN;
        end
        default: begin
          state_reg <= ST_OFF;
        end
      endcase
    end
  end

  always @(posedge sys_clk_i) begin
    if (sys_rst_i) begin
      converter_power_enable_o <= 1'b0;
      converter_reset_o <= 1'b1;
      input_buffer_bypass_o <= 2'h0;
      diagnostic_current_select_o <= 2'h0;
      output_coding_select_o <= 1'b0;
      input_channel_select_o <= 3'h0;
      reference_select_o <= 1'b0;
      voltage_result_ready_o <= 1'b0;
      temperature_result_ready_o <= 1'b0;
      result_o <= 24'h000000;
    end else begin
      converter_power_enable_o <= enabled;
      converter_reset_o <= ctrl_wr || (state_reg == ST_WAIT && !primary_frame_i) || state_reg == ST_OFF;
      input_buffer_bypass_o <= ctrl_reg[`BYP_HI:`BYP_LO];
      diagnostic_current_select_o <= ctrl_reg[`DIAG_HI:`DIAG_LO];
      output_coding_select_o <= ctrl_reg[`CODE_BIT];
      input_channel_select_o <= ctrl_reg[`CH_HI:`CH_LO];
      reference_select_o <= ctrl_reg[`REF_BIT];
      // disable or restart clears ready flags
      if (ctrl_wr || !running) begin
        voltage_result_ready_o <= 1'b0;
        temperature_result_ready_o <= 1'b0;
      end else begin
        if (conv_volt_done_i) begin
          voltage_result_ready_o <= 1'b1;
        end
        if (conv_temp_done_i) begin
          temperature_result_ready_o <= 1'b1;
        end
      end
      if (running && (conv_volt_done_i || conv_temp_done_i)) begin
        result_o <= coded;
      end
    end
  end

  // sticky status, set wins over clear
  always @(posedge sys_clk_i) begin
    if (sys_rst_i) begin
      status_reg <= `STATUS_RESET;
      mask_reg <= `MASK_RESET;
      irq_o <= 1'b0;
    end else begin
      status_reg <= (status_reg & ~(stat_wr ? wdata_i[2:0] : 3'h0)) | events;
      if (mask_wr) begin
        mask_reg <= wdata_i[2:0];
      end
      irq_o <= |(((status_reg & ~(stat_wr ? wdata_i[2:0] : 3'h0)) | events) & (mask_wr ? wdata_i[2:0] : mask_reg));
    end
  end

  always @(posedge sys_clk_i) begin
    if (sys_rst_i) begin
      rdata_o <= 32'h00000000;
    end else if (rd_i) begin
      case (addr_i)
        `CTRL_OFFSET: rdata_o <= ctrl_reg;
        `STATUS_OFFSET: rdata_o <= {29'h00000000, status_reg};
        `IRQ_MASK_OFFSET: rdata_o <= {29'h00000000, mask_reg};
        default: rdata_o <= 32'h00000000;
      endcase
    end else begin
      rdata_o <= 32'h00000000;
    end
  end
endmodule

// ---- voltage_temp_adc_control_chk.sv ----
`timescale 1ns/10ps
`include "vt_conv_regs.vh"
module voltage_temp_adc_control_chk (
  input wire sys_clk_i,
  input wire sys_rst_i,
  input wire [31:0] addr_i,
  input wire [31:0] wdata_i,
  input wire wr_i,
  input wire primary_frame_i,
  input wire converter_power_enable_o,
  input wire converter_reset_o,
  input wire [1:0] input_buffer_bypass_o,
  input wire [1:0] diagnostic_current_select_o,
  input wire output_coding_select_o,
  input wire [2:0] input_channel_select_o,
  input wire voltage_result_ready_o,
  input wire [23:0] result_o
);
  wire w = wr_i && addr_i == `CTRL_OFFSET;
  default clocking @(posedge sys_clk_i); endclocking
  default disable iff (sys_rst_i);
  a_write_resets_conv: assert property (w |=> converter_reset_o) else $error("no restart");
  a_release_on_frame: assert property ($fell(converter_reset_o) |-> $past(primary_frame_i)) else $error("unaligned");
  a_no_early_ready: assert property (converter_reset_o |-> !voltage_result_ready_o) else $error("early");
  a_off_clears_ready: assert property (!converter_power_enable_o |-> !voltage_result_ready_o) else $error("off");
  a_bypass_follows: assert property (w |=> ##1 input_buffer_bypass_o == $past(wdata_i[17:16], 2))
    else $error("bypass");
  a_diag_follows: assert property (w |=> ##1 diagnostic_current_select_o == $past(wdata_i[13:12], 2))
    else $error("diag");
  a_chan_follows: assert property (w |=> ##1 input_channel_select_o == $past(wdata_i[8:6], 2))
    else $error("chan");
  a_unipolar_zero: assert property ($rose(voltage_result_ready_o) && output_coding_select_o |-> !result_o[23])
    else $error("unipolar");
  cover property ($fell(converter_reset_o));
  cover property ($rose(voltage_result_ready_o));
  cover property ($rose(voltage_result_ready_o) && output_coding_select_o);
endmodule
bind voltage_temp_adc_control voltage_temp_adc_control_chk chk (.*);

// ---- tb_voltage_temp_adc_control.sv ----
`timescale 1ns/10ps
`include "vt_conv_regs.vh"
module tb_voltage_temp_adc_control;
  reg sys_clk_i = 0, sys_rst_i = 1, wr_i = 0, rd_i = 0, pf = 0, vd = 0, td = 0;
  reg [31:0] addr_i = 0, wdata_i = 0, m, d;
  reg [23:0] cd = 0;
  wire [31:0] rdata_o;
  wire en, cr, cod, rf, vr, tr, irq;
  wire [1:0] byp, dg;
  wire [2:0] ch;
  wire [23:0] res;
  integer errors = 0, n_checks = 0, cyc = 0, i;
  voltage_temp_adc_control #(.SETTLE_CYCLES(8)) uut (.sys_clk_i(sys_clk_i), .sys_rst_i(sys_rst_i),
    .addr_i(addr_i), .wdata_i(wdata_i), .wr_i(wr_i), .rd_i(rd_i), .rdata_o(rdata_o), .primary_frame_i(pf),
    .conv_volt_done_i(vd), .conv_temp_done_i(td), .conv_data_i(cd), .converter_power_enable_o(en),
    .converter_reset_o(cr), .input_buffer_bypass_o(byp), .diagnostic_current_select_o(dg),
    .output_coding_select_o(cod), .input_channel_select_o(ch), .reference_select_o(rf),
    .voltage_result_ready_o(vr), .temperature_result_ready_o(tr), .result_o(res), .irq_o(irq));
  initial forever #10 sys_clk_i = ~sys_clk_i;
  always @(posedge sys_clk_i) begin
    cyc <= cyc + 1;
    if (cyc > 3000) begin
      errors = errors + 1;
      report_and_stop;
    end
  end
  task chk(input [31:0] got, input [31:0] exp);
    begin
      n_checks = n_checks + 1;
      if (got !== exp) begin
        errors = errors + 1;
        $display("ERROR %0t got %h exp %h", $time, got, exp);
      end
    end
  endtask
  task wr(input [31:0] a, input [31:0] v);
    begin
      @(posedge sys_clk_i);
      wr_i <= 1;
      addr_i <= a;
      wdata_i <= v;
      @(posedge sys_clk_i);
      wr_i <= 0;
    end
  endtask
  task rd(input [31:0] a, input [31:0] e);
    begin
      @(posedge sys_clk_i);
      rd_i <= 1;
      addr_i <= a;
      @(posedge sys_clk_i);
      rd_i <= 0;
      #1 chk(rdata_o, e);
    end
  endtask
  task pulse(input [23:0] v);
    begin
      cd <= v;
      vd <= 1;
      td <= 1;
      @(posedge sys_clk_i);
      vd <= 0;
      td <= 0;
      #1;
    end
  endtask
  task run(input c, input [23:0] v);
    begin
      wr(`CTRL_OFFSET, 32'h00080000 | (c << 9));
      repeat (3) @(posedge sys_clk_i);
      pf <= 1;
      @(posedge sys_clk_i);
      pf <= 0;
      pulse(~v);
      chk({vr, tr}, 0);
      // last settling cycle: pulse must still be ignored
      repeat (6) @(posedge sys_clk_i);
      pulse(~v);
      chk({vr, tr}, 0);
      repeat (5) @(posedge sys_clk_i);
      pulse(v);
      chk({vr, tr, res}, {2'b11, (c && v[23]) ? 24'h000000 : v});
    end
  endtask
  initial begin
    d = $urandom(32'h3D91);
    repeat (10) @(posedge sys_clk_i);
    sys_rst_i <= 0;
    rd(`CTRL_OFFSET, 0);
    rd(32'h40030020, 0);
    for (i = 0; i < 8; i = i + 1) begin
      d = $urandom;
      d[8:6] = i;
      // bypass both only while powered down
      d[19] = (i != 7);
      d[17:16] = (i == 7) ? 2'h3 : i % 3;
      m = d & `CTRL_IMPL_MASK;
      wr(`CTRL_OFFSET, d);
      @(posedge sys_clk_i);
      #1 chk({en, byp, dg, cod, ch, rf}, {m[19], m[17:16], m[13:12], m[9], m[8:6], m[4]});
      rd(`CTRL_OFFSET, m);
    end
    run(0, $urandom);
    run(1, 24'h9ABCDE);
    rd(`STATUS_OFFSET, 7);
    wr(`IRQ_MASK_OFFSET, 1);
    @(posedge sys_clk_i);
    #1 chk(irq, 1);
    wr(`STATUS_OFFSET, 7);
    @(posedge sys_clk_i);
    #1 chk(irq, 0);
    wr(`CTRL_OFFSET, 0);
    #1 chk({vr, tr}, 0);
    report_and_stop;
  end
  task report_and_stop;
    begin
      $display("checks %0d errors %0d", n_checks, errors);
      if (errors == 0 && n_checks > 0)
        $display("Result: passed");
      else
        $display("Result: failed");
      $finish;
    end
  endtask
endmodule
